/* File: inc/cfr_regs_map.svh */
// Notes on behaviour
// [RL1] Bank select routes singles to bank 0/1
// [RL2] Extended singles use the opposite bank
// [RL3] Doubles pair singles; quads join four singles
// [RL4] Extended pairs join two extended singles
// [RL5] Matrix holds extended singles column by column
// [RL6] Privilege bit clear refuses privileged resources
// [RL7] Integer bank bit set on reset/exception
// [RL8] Block bit masks interrupts, escalates exceptions
// [RL9] FPU disable raises exception, slot variant
// [RL10] Level mask blocks interrupts at or below it, kept
// [RL11] Reserved status bits read and write zero
// [RL12] Exception saves status, address, stack copy
// [RL13] Vector base resets zero; debug base override
// [RL14] Program counter resets to its reset value
// [RL15] FP control word resets; high bits reserved
// [RL16] Move size picks 32-bit or pair moves
// [RL17] Precision bit picks single or double
// [RL18] Software never sets move size with precision
// [RL19] Denormal bit flushes denormals to zero
// [RL20] Operation clears cause, exception sets cause
// [RL21] Flags set with cause, sticky until cleared
// [RL22] Rounding field: nearest, zero, rest reserved
// [RL23] Reset or exception entry sets privilege bit
// [RL24] Enabled exception or error raises trap
`ifndef CFR_REGS_MAP_SVH
`define CFR_REGS_MAP_SVH
`define CFR_SR_RESET 32'h7000_00F0
`define CFR_SR_WMASK 32'h7000_83F3
`define CFR_SR_MD 30
`define CFR_SR_RB 29
`define CFR_SR_BL 28
`define CFR_SR_FD 15
`define CFR_SR_INTERRUPT_LEVEL_MASK_HI 7
`define CFR_SR_INTERRUPT_LEVEL_MASK_LO 4
`define CFR_VBR_RESET 32'h0000_0000
`define CFR_PC_RESET 32'hA000_0000
`define CFR_FP_STATUS_CONTROL_RESET 32'h0004_0001
`define CFR_FP_STATUS_CONTROL_WMASK 32'h003F_FFFF
`define CFR_FP_STATUS_CONTROL_FR 21
`define CFR_FP_STATUS_CONTROL_SZ 20
`define CFR_FP_STATUS_CONTROL_PR 19
`define CFR_FP_STATUS_CONTROL_DN 18
`define CFR_FP_STATUS_CONTROL_CAUSE_HI 17
`define CFR_FP_STATUS_CONTROL_CAUSE_LO 12
`define CFR_FP_STATUS_CONTROL_EN_HI 11
`define CFR_FP_STATUS_CONTROL_EN_LO 7
`define CFR_FP_STATUS_CONTROL_FLAG_HI 6
`define CFR_FP_STATUS_CONTROL_FLAG_LO 2
`define CFR_FP_STATUS_CONTROL_RM_HI 1
`define CFR_FP_STATUS_CONTROL_RM_LO 0
`endif

/* File: inc/cfr_pkg.sv */
package cfr_pkg;
  typedef enum logic [3:0] {
    CFR_SEL_SR = 4'h0,
    CFR_SEL_SSR = 4'h1,
    CFR_SEL_SPC = 4'h2,
    CFR_SEL_GBR = 4'h3,
    CFR_SEL_VBR = 4'h4,
    CFR_SEL_SGR = 4'h5,
    CFR_SEL_DBR = 4'h6,
    CFR_SEL_MULTIPLY_ACCUM_HIGH = 4'h7,
    CFR_SEL_MULTIPLY_ACCUM_LOW = 4'h8,
    CFR_SEL_PR = 4'h9,
    CFR_SEL_FP_STATUS_CONTROL = 4'hA,
    CFR_SEL_FP_INT_TRANSFER_WORD = 4'hB,
    CFR_SEL_PC = 4'hC
  } cfr_ctl_sel_e;

  // Order E, V, Z, O, U, I from bit 5 down
  typedef logic [5:0] cfr_fp_exc_t;

  typedef struct packed {
    logic [15:0][31:0] single;
    logic [15:0][31:0] ext;
    logic [7:0][63:0] dbl;
    logic [3:0][127:0] quad;
    logic [7:0][63:0] xpair;
    logic [3:0][3:0][31:0] matrix;
  } cfr_fp_views_s;

  typedef struct packed {
    logic move_64;
    logic double_prec;
    logic denorm_flush;
    logic [1:0] rounding;
    logic reserved_mode;
  } cfr_fp_mode_s;
endpackage

/* File: hw/cfr_regs.sv */
`timescale 1ns/10ps
`include "cfr_regs_map.svh"
module cfr_regs
  import cfr_pkg::*;
#(
  parameter int NUM_FPR = 16
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control register access by instruction
  input wire logic ctl_wr_i,
  input wire logic ctl_rd_i,
  input wire cfr_ctl_sel_e ctl_sel_i,
  input wire logic [31:0] ctl_wdata_i,
  output logic [31:0] ctl_rdata_o,
  output logic ctl_refused_o,
  // Floating-point register writes
  input wire logic fp_wr_i,
  input wire logic fp_wr_ext_i,
  input wire logic [3:0] fp_wr_idx_i,
  input wire logic [63:0] fp_wr_data_i,
  output cfr_fp_views_s fp_views_o,
  // Floating-point operation events
  input wire logic fp_op_i,
  input wire logic fp_op_slot_i,
  input wire logic fp_exc_valid_i,
  input wire cfr_fp_exc_t fp_exc_bits_i,
  output logic fpu_dis_exc_o,
  output logic fpu_dis_slot_o,
  output logic fp_trap_o,
  output cfr_fp_mode_s fp_mode_o,
  // Exceptions and interrupts
  input wire logic exc_i,
  input wire logic exc_user_break_i,
  input wire logic [31:0] exc_pc_i,
  input wire logic [31:0] exc_r15_i,
  input wire logic [31:0] exc_offset_i,
  input wire logic break_debug_enable_i,
  input wire logic irq_i,
  input wire logic [3:0] irq_level_i,
  output logic irq_take_o,
  output logic reset_state_o,
  // Program counter
  input wire logic pc_wr_i,
  input wire logic [31:0] pc_wdata_i,
  output logic [31:0] pc_o,
  // Mode view for the core
  output logic privilege_level_o,
  output logic gpr_bank_select_o,
  output logic exception_block_o
);

  logic [31:0] fp_physical_cell [2][NUM_FPR];
  logic [31:0] sr_reg, ssr_reg, spc_reg, gbr_reg, vbr_reg, sgr_reg, dbr_reg;
  logic [31:0] multiply_accum_high_reg, multiply_accum_low_reg, pr_reg, fp_status_control_reg, fp_int_transfer_word_reg, pc_reg;
  logic [31:0] fp_status_control_next, rdata_next, target;
  logic fp_bank_select, fp_move_size, fpu_disable, privileged;
  logic [3:0] interrupt_level_mask;
  logic sel_priv, sel_fpu, wr_refused, wr_ok, exc_take, enter_reset;
  logic wr_bank;
  logic [3:0] wr_even;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign fp_bank_select = fp_status_control_reg[`CFR_FP_STATUS_CONTROL_FR];
  assign fp_move_size = fp_status_control_reg[`CFR_FP_STATUS_CONTROL_SZ];
  assign fpu_disable = sr_reg[`CFR_SR_FD];
  assign privileged = sr_reg[`CFR_SR_MD];
  assign interrupt_level_mask = sr_reg[`CFR_SR_INTERRUPT_LEVEL_MASK_HI:`CFR_SR_INTERRUPT_LEVEL_MASK_LO];

  always_comb
  begin
    sel_priv = 1'b0;
    sel_fpu = 1'b0;
    unique case (ctl_sel_i)
      CFR_SEL_SR, CFR_SEL_SSR, CFR_SEL_SPC, CFR_SEL_VBR, CFR_SEL_SGR, CFR_SEL_DBR:
        sel_priv = 1'b1;
      CFR_SEL_FP_STATUS_CONTROL, CFR_SEL_FP_INT_TRANSFER_WORD:
        sel_fpu = 1'b1;
      default:
        sel_priv = 1'b0;
    endcase
  end

  // User mode may not touch privileged registers; PC is never written here
  assign wr_refused = (ctl_wr_i || ctl_rd_i) &&
                      ((sel_priv && !privileged) || (sel_fpu && fpu_disable) || // RL6
                       (ctl_wr_i && ctl_sel_i == CFR_SEL_PC));
  assign ctl_refused_o = wr_refused;
  // An exception in the same cycle wins over the instruction's write
  assign wr_ok = ctl_wr_i && !wr_refused && !exc_i;

  // Under the block bit a general exception other than a user break resets
  assign enter_reset = exc_i && sr_reg[`CFR_SR_BL] && !exc_user_break_i; // RL8
  assign exc_take = exc_i && !enter_reset;
  assign reset_state_o = enter_reset;

  assign irq_take_o = irq_i && !sr_reg[`CFR_SR_BL] && // RL8
                      (irq_level_i > interrupt_level_mask); // RL10

  assign fpu_dis_exc_o = fp_op_i && fpu_disable && !fp_op_slot_i; // RL9
  assign fpu_dis_slot_o = fp_op_i && fpu_disable && fp_op_slot_i; // RL9

  assign target = (exc_user_break_i && break_debug_enable_i) ? dbr_reg : // RL13
                  vbr_reg + exc_offset_i; // RL13

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || enter_reset)
    begin
      sr_reg <= `CFR_SR_RESET; // RL7 RL8 RL9 RL23
    end
    else if (exc_take)
    begin
      // Level mask is deliberately left alone
      sr_reg[`CFR_SR_MD] <= 1'b1; // RL23
      sr_reg[`CFR_SR_RB] <= 1'b1; // RL7
      sr_reg[`CFR_SR_BL] <= 1'b1; // RL8
    end
    else if (wr_ok && ctl_sel_i == CFR_SEL_SR)
    begin
      sr_reg <= ctl_wdata_i & `CFR_SR_WMASK; // RL11
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (exc_take)
    begin
      ssr_reg <= sr_reg; // RL12
      spc_reg <= exc_pc_i; // RL12
      sgr_reg <= exc_r15_i; // RL12
    end
    else if (wr_ok)
    begin
      if (ctl_sel_i == CFR_SEL_SSR)
      begin
        ssr_reg <= ctl_wdata_i;
      end
      if (ctl_sel_i == CFR_SEL_SPC)
      begin
        spc_reg <= ctl_wdata_i;
      end
      if (ctl_sel_i == CFR_SEL_SGR)
      begin
        sgr_reg <= ctl_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control and system registers

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || enter_reset)
    begin
      vbr_reg <= `CFR_VBR_RESET; // RL13
    end
    else if (wr_ok && ctl_sel_i == CFR_SEL_VBR)
    begin
      vbr_reg <= ctl_wdata_i;
    end
  end

  // Undefined after reset in the architecture; cleared here for clean sims
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      gbr_reg <= 32'h0000_0000;
      dbr_reg <= 32'h0000_0000;
      multiply_accum_high_reg <= 32'h0000_0000;
      multiply_accum_low_reg <= 32'h0000_0000;
      pr_reg <= 32'h0000_0000;
      fp_int_transfer_word_reg <= 32'h0000_0000;
    end
    else if (wr_ok)
    begin
      unique case (ctl_sel_i)
        CFR_SEL_GBR: gbr_reg <= ctl_wdata_i;
        CFR_SEL_DBR: dbr_reg <= ctl_wdata_i;
        CFR_SEL_MULTIPLY_ACCUM_HIGH: multiply_accum_high_reg <= ctl_wdata_i;
        CFR_SEL_MULTIPLY_ACCUM_LOW: multiply_accum_low_reg <= ctl_wdata_i;
        CFR_SEL_PR: pr_reg <= ctl_wdata_i;
        CFR_SEL_FP_INT_TRANSFER_WORD: fp_int_transfer_word_reg <= ctl_wdata_i;
        default: pr_reg <= pr_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || enter_reset)
    begin
      pc_reg <= `CFR_PC_RESET; // RL14
    end
    else if (exc_take)
    begin
      pc_reg <= target; // RL13
    end
    else if (pc_wr_i)
    begin
      pc_reg <= pc_wdata_i; // RL14
    end
  end

  assign pc_o = pc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Floating-point status/control word

  always_comb
  begin
    fp_status_control_next = fp_status_control_reg;
    if (wr_ok && ctl_sel_i == CFR_SEL_FP_STATUS_CONTROL)
    begin
      fp_status_control_next = ctl_wdata_i & `CFR_FP_STATUS_CONTROL_WMASK; // RL11 RL15
    end
    if (fp_op_i && !fpu_disable)
    begin
      fp_status_control_next[`CFR_FP_STATUS_CONTROL_CAUSE_HI:`CFR_FP_STATUS_CONTROL_CAUSE_LO] = 6'h00; // RL20
    end
    // Hardware set wins over a software clear in the same cycle
    if (fp_exc_valid_i)
    begin
      fp_status_control_next[`CFR_FP_STATUS_CONTROL_CAUSE_HI:`CFR_FP_STATUS_CONTROL_CAUSE_LO] =
        fp_status_control_next[`CFR_FP_STATUS_CONTROL_CAUSE_HI:`CFR_FP_STATUS_CONTROL_CAUSE_LO] | fp_exc_bits_i; // RL20
      fp_status_control_next[`CFR_FP_STATUS_CONTROL_FLAG_HI:`CFR_FP_STATUS_CONTROL_FLAG_LO] =
        fp_status_control_next[`CFR_FP_STATUS_CONTROL_FLAG_HI:`CFR_FP_STATUS_CONTROL_FLAG_LO] | fp_exc_bits_i[4:0]; // RL21
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || enter_reset)
    begin
      fp_status_control_reg <= `CFR_FP_STATUS_CONTROL_RESET; // RL15
    end
    else
    begin
      fp_status_control_reg <= fp_status_control_next;
    end
  end

  // Error has no enable bit and always traps
  assign fp_trap_o = fp_exc_valid_i && (fp_exc_bits_i[5] || // RL24
                     |(fp_exc_bits_i[4:0] & fp_status_control_reg[`CFR_FP_STATUS_CONTROL_EN_HI:`CFR_FP_STATUS_CONTROL_EN_LO]));

  assign fp_mode_o.move_64 = fp_move_size; // RL16
  assign fp_mode_o.double_prec = fp_status_control_reg[`CFR_FP_STATUS_CONTROL_PR]; // RL17
  assign fp_mode_o.denorm_flush = fp_status_control_reg[`CFR_FP_STATUS_CONTROL_DN]; // RL19
  assign fp_mode_o.rounding = fp_status_control_reg[`CFR_FP_STATUS_CONTROL_RM_HI:`CFR_FP_STATUS_CONTROL_RM_LO]; // RL22
  // Flags the reserved combinations; results are not guaranteed then
  assign fp_mode_o.reserved_mode = (fp_move_size && fp_status_control_reg[`CFR_FP_STATUS_CONTROL_PR]) || // RL18
                                   fp_status_control_reg[`CFR_FP_STATUS_CONTROL_RM_HI]; // RL22

  ////////////////////////////////////////////////////////////////////////////
  // Floating-point register array and its views

  // Extended writes land in the bank opposite the singles
  assign wr_bank = fp_wr_ext_i ^ fp_bank_select; // RL1 RL2
  assign wr_even = {fp_wr_idx_i[3:1], 1'b0};

  always_ff @(posedge clk_i)
  begin
    if (fp_wr_i && !fpu_disable)
    begin
      if (fp_move_size)
      begin
        // Pair moves write the even cell high, the odd cell low
        fp_physical_cell[wr_bank][wr_even] <= fp_wr_data_i[63:32]; // RL16
        fp_physical_cell[wr_bank][wr_even | 4'h1] <= fp_wr_data_i[31:0]; // RL16
      end
      else
      begin
        fp_physical_cell[wr_bank][fp_wr_idx_i] <= fp_wr_data_i[31:0]; // RL16
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FPR; gi++)
    begin : g_single
      assign fp_views_o.single[gi] = fp_physical_cell[fp_bank_select][gi]; // RL1
      assign fp_views_o.ext[gi] = fp_physical_cell[!fp_bank_select][gi]; // RL2
      assign fp_views_o.matrix[gi / 4][gi % 4] = fp_views_o.ext[gi]; // RL5
    end
    for (gi = 0; gi < NUM_FPR / 2; gi++)
    begin : g_pair
      assign fp_views_o.dbl[gi] = {fp_views_o.single[2 * gi],
                                   fp_views_o.single[2 * gi + 1]}; // RL3
      assign fp_views_o.xpair[gi] = {fp_views_o.ext[2 * gi],
                                     fp_views_o.ext[2 * gi + 1]}; // RL4
    end
    for (gi = 0; gi < NUM_FPR / 4; gi++)
    begin : g_quad
      assign fp_views_o.quad[gi] = {fp_views_o.dbl[2 * gi], fp_views_o.dbl[2 * gi + 1]}; // RL3
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (ctl_sel_i)
      CFR_SEL_SR: rdata_next = sr_reg & `CFR_SR_WMASK; // RL11
      CFR_SEL_SSR: rdata_next = ssr_reg;
      CFR_SEL_SPC: rdata_next = spc_reg;
      CFR_SEL_GBR: rdata_next = gbr_reg;
      CFR_SEL_VBR: rdata_next = vbr_reg;
      CFR_SEL_SGR: rdata_next = sgr_reg;
      CFR_SEL_DBR: rdata_next = dbr_reg;
      CFR_SEL_MULTIPLY_ACCUM_HIGH: rdata_next = multiply_accum_high_reg;
      CFR_SEL_MULTIPLY_ACCUM_LOW: rdata_next = multiply_accum_low_reg;
      CFR_SEL_PR: rdata_next = pr_reg;
      CFR_SEL_FP_STATUS_CONTROL: rdata_next = fp_status_control_reg & `CFR_FP_STATUS_CONTROL_WMASK; // RL11
      CFR_SEL_FP_INT_TRANSFER_WORD: rdata_next = fp_int_transfer_word_reg;
      CFR_SEL_PC: rdata_next = pc_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Refused reads return zero rather than leaking privileged state
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      ctl_rdata_o <= 32'h0000_0000;
    end
    else if (ctl_rd_i)
    begin
      ctl_rdata_o <= wr_refused ? 32'h0000_0000 : rdata_next; // RL6
    end
  end

  assign privilege_level_o = privileged; // RL6
  assign gpr_bank_select_o = privileged & sr_reg[`CFR_SR_RB]; // RL7
  assign exception_block_o = sr_reg[`CFR_SR_BL];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_EXC_SAVE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL12
    exc_take |=> (ssr_reg == $past(sr_reg)) && (spc_reg == $past(exc_pc_i)) &&
                 (sgr_reg == $past(exc_r15_i)))
    else $error("exception did not save state");
  AST_EXC_MODE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL23
    exc_take |=> sr_reg[`CFR_SR_MD] && sr_reg[`CFR_SR_RB] && sr_reg[`CFR_SR_BL] &&
                 (interrupt_level_mask == $past(interrupt_level_mask)))
    else $error("exception entry mode bits wrong");
  AST_BL_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL8
    (exc_i && exception_block_o && !exc_user_break_i) |=>
      (pc_reg == `CFR_PC_RESET) && (sr_reg == `CFR_SR_RESET) && (vbr_reg == 32'h0000_0000))
    else $error("blocked exception did not reset");
  AST_IRQ_MASK: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL10
    irq_take_o |-> !exception_block_o && (irq_level_i > interrupt_level_mask))
    else $error("masked interrupt taken");
  AST_FD_EXC: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL9
    (fp_op_i && fpu_disable) |-> (fpu_dis_exc_o != fpu_dis_slot_o) &&
                                 (fpu_dis_slot_o == fp_op_slot_i))
    else $error("fpu disable exception wrong");
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL21
    !(wr_ok && ctl_sel_i == CFR_SEL_FP_STATUS_CONTROL) && !enter_reset |=>
      ((fp_status_control_reg[6:2] & $past(fp_status_control_reg[6:2])) == $past(fp_status_control_reg[6:2])))
    else $error("fp flag lost");
  AST_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL20
    (fp_op_i && !fpu_disable && !exc_i) |=>
      (fp_status_control_reg[17:12] == $past(fp_exc_valid_i ? fp_exc_bits_i : 6'h00)))
    else $error("cause field wrong");
  AST_EXC_TARGET: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL13
    (exc_take && !(exc_user_break_i && break_debug_enable_i)) |=>
      (pc_reg == $past(vbr_reg) + $past(exc_offset_i)))
    else $error("exception target wrong");
  AST_PAIR_WR: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL3
    (fp_wr_i && !fpu_disable && fp_move_size && !fp_wr_ext_i && !ctl_wr_i &&
     !fp_exc_valid_i && !exc_i) |=>
      (fp_views_o.dbl[$past(fp_wr_idx_i[3:1])] == $past(fp_wr_data_i)))
    else $error("pair write not seen in double view");
  AST_RESVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL11
    (fp_status_control_reg[31:22] == 10'h000) && ((sr_reg & ~`CFR_SR_WMASK) == 32'h0000_0000))
    else $error("reserved bit set");
endmodule

/* File: tb/cfr_regs_tb.sv */
`timescale 1ns/10ps
module tb;
  import cfr_pkg::*;
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic ctl_wr_i = 1'h0;
  logic ctl_rd_i = 1'h0;
  cfr_ctl_sel_e ctl_sel_i = CFR_SEL_SR;
  logic [31:0] ctl_wdata_i = 32'h0000_0000;
  logic [31:0] ctl_rdata_o;
  logic ctl_refused_o;
  logic fp_wr_i = 1'h0;
  logic fp_wr_ext_i = 1'h0;
  logic [3:0] fp_wr_idx_i = 4'h0;
  logic [63:0] fp_wr_data_i = 64'h0000_0000_0000_0000;
  cfr_fp_views_s fp_views_o;
  logic fp_op_i = 1'h0;
  logic fp_op_slot_i = 1'h0;
  logic fp_exc_valid_i = 1'h0;
  cfr_fp_exc_t fp_exc_bits_i = 6'h00;
  logic fpu_dis_exc_o, fpu_dis_slot_o, fp_trap_o;
  cfr_fp_mode_s fp_mode_o;
  logic exc_i = 1'h0;
  logic exc_user_break_i = 1'h0;
  logic [31:0] exc_pc_i = 32'h0000_0000;
  logic [31:0] exc_r15_i = 32'h0000_0000;
  logic [31:0] exc_offset_i = 32'h0000_0000;
  logic break_debug_enable_i = 1'h0;
  logic irq_i = 1'h0;
  logic [3:0] irq_level_i = 4'h0;
  logic irq_take_o, reset_state_o;
  logic pc_wr_i = 1'h0;
  logic [31:0] pc_wdata_i = 32'h0000_0000;
  logic [31:0] pc_o;
  logic privilege_level_o, gpr_bank_select_o, exception_block_o;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [31:0] SB = 32'h1000_0000;
  localparam logic [31:0] XB = 32'h2000_0000;

  cfr_regs #(.NUM_FPR(16)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ctl_wr_i(ctl_wr_i), .ctl_rd_i(ctl_rd_i),
    .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rdata_o(ctl_rdata_o),
    .ctl_refused_o(ctl_refused_o), .fp_wr_i(fp_wr_i), .fp_wr_ext_i(fp_wr_ext_i),
    .fp_wr_idx_i(fp_wr_idx_i), .fp_wr_data_i(fp_wr_data_i), .fp_views_o(fp_views_o),
    .fp_op_i(fp_op_i), .fp_op_slot_i(fp_op_slot_i), .fp_exc_valid_i(fp_exc_valid_i),
    .fp_exc_bits_i(fp_exc_bits_i), .fpu_dis_exc_o(fpu_dis_exc_o),
    .fpu_dis_slot_o(fpu_dis_slot_o), .fp_trap_o(fp_trap_o), .fp_mode_o(fp_mode_o),
    .exc_i(exc_i), .exc_user_break_i(exc_user_break_i), .exc_pc_i(exc_pc_i),
    .exc_r15_i(exc_r15_i), .exc_offset_i(exc_offset_i),
    .break_debug_enable_i(break_debug_enable_i), .irq_i(irq_i),
    .irq_level_i(irq_level_i), .irq_take_o(irq_take_o), .reset_state_o(reset_state_o),
    .pc_wr_i(pc_wr_i), .pc_wdata_i(pc_wdata_i), .pc_o(pc_o),
    .privilege_level_o(privilege_level_o), .gpr_bank_select_o(gpr_bank_select_o),
    .exception_block_o(exception_block_o)
  );

  always #25 clk_i = !clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reads compare data half a cycle after the taking edge; refused reads give zero
  task automatic acc(input logic w, input cfr_ctl_sel_e s, input logic [31:0] d,
                     input logic rf);
    @(negedge clk_i);
    ctl_wr_i = w;
    ctl_rd_i = !w;
    ctl_sel_i = s;
    ctl_wdata_i = d;
    #1;
    chk("refused", rf, ctl_refused_o);
    @(negedge clk_i);
    ctl_wr_i = 1'h0;
    ctl_rd_i = 1'h0;
    if (!w)
      chk("rdata", d, ctl_rdata_o);
  endtask

  task automatic wr(input cfr_ctl_sel_e s, input logic [31:0] d);
    acc(1'h1, s, d, 1'h0);
  endtask

  task automatic rd(input cfr_ctl_sel_e s, input logic [31:0] d);
    acc(1'h0, s, d, 1'h0);
  endtask

  task automatic fpw(input logic x, input logic [3:0] i, input logic [63:0] d);
    @(negedge clk_i);
    fp_wr_i = 1'h1;
    fp_wr_ext_i = x;
    fp_wr_idx_i = i;
    fp_wr_data_i = d;
    @(negedge clk_i);
    fp_wr_i = 1'h0;
  endtask

  task automatic fpev(input logic op, input logic sl, input logic v, input cfr_fp_exc_t b,
                      input logic [2:0] e);
    @(negedge clk_i);
    fp_op_i = op;
    fp_op_slot_i = sl;
    fp_exc_valid_i = v;
    fp_exc_bits_i = b;
    #1;
    chk("trap_dis_slot", e, {fp_trap_o, fpu_dis_exc_o, fpu_dis_slot_o});
    @(negedge clk_i);
    fp_op_i = 1'h0;
    fp_op_slot_i = 1'h0;
    fp_exc_valid_i = 1'h0;
  endtask

  task automatic exc(input logic ub, input logic [31:0] pc, input logic [31:0] r15,
                     input logic rs);
    @(negedge clk_i);
    exc_i = 1'h1;
    exc_user_break_i = ub;
    break_debug_enable_i = ub;
    exc_pc_i = pc;
    exc_r15_i = r15;
    exc_offset_i = 32'h0000_0600;
    #1;
    chk("reset_state", rs, reset_state_o);
    @(negedge clk_i);
    exc_i = 1'h0;
  endtask

  task automatic irq(input logic [3:0] lv, input logic t);
    @(negedge clk_i);
    irq_i = 1'h1;
    irq_level_i = lv;
    #1;
    chk("irq_take", t, irq_take_o);
    @(negedge clk_i);
    irq_i = 1'h0;
  endtask

  // Every view is derived from the two fill bases, so one pass covers all aliases
  task automatic vchk(input logic [31:0] sb, input logic [31:0] xb);
    for (int i = 0; i < 16; i++)
    begin
      chk("single", sb + i, fp_views_o.single[i]);
      chk("ext", xb + i, fp_views_o.ext[i]);
      chk("matrix", xb + i, fp_views_o.matrix[i / 4][i % 4]);
    end
    for (int k = 0; k < 8; k++)
    begin
      chk("dbl", {32'(sb + 2 * k), 32'(sb + 2 * k + 1)}, fp_views_o.dbl[k]);
      chk("xpair", {32'(xb + 2 * k), 32'(xb + 2 * k + 1)}, fp_views_o.xpair[k]);
    end
    for (int k = 0; k < 4; k++)
      chk("quad", {32'(sb + 4 * k), 32'(sb + 4 * k + 1), 32'(sb + 4 * k + 2),
                   32'(sb + 4 * k + 3)}, fp_views_o.quad[k]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'h1;
    rd(CFR_SEL_SR, 32'h7000_00F0);
    chk("mode_bits", 3'h7, {privilege_level_o, gpr_bank_select_o, exception_block_o});
    rd(CFR_SEL_VBR, 32'h0000_0000);
    rd(CFR_SEL_PC, 32'hA000_0000);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0004_0001);
    chk("fp_mode", 6'h0A, fp_mode_o);
    acc(1'h1, CFR_SEL_PC, 32'h0000_0000, 1'h1);
    @(negedge clk_i);
    pc_wr_i = 1'h1;
    pc_wdata_i = 32'h0000_1000;
    @(negedge clk_i);
    pc_wr_i = 1'h0;
    chk("pc", 32'h0000_1000, pc_o);
    // Writes set only writable bits and read back unchanged; FD must drop before FP_STATUS_CONTROL is reachable
    wr(CFR_SEL_SR, 32'h7000_83F3);
    rd(CFR_SEL_SR, 32'h7000_83F3);
    wr(CFR_SEL_SR, 32'h7000_00F0);
    wr(CFR_SEL_FP_STATUS_CONTROL, 32'h0037_FFFF);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0037_FFFF);
    wr(CFR_SEL_FP_STATUS_CONTROL, 32'h0004_0001);
    $display("test reset done");

    for (int i = 0; i < 16; i++)
    begin
      fpw(1'h0, 4'(i), {32'h0000_0000, 32'(SB + i)});
      fpw(1'h1, 4'(i), {32'h0000_0000, 32'(XB + i)});
    end
    vchk(SB, XB);
    wr(CFR_SEL_FP_STATUS_CONTROL, 32'h0024_0001);
    vchk(XB, SB);
    wr(CFR_SEL_FP_STATUS_CONTROL, 32'h0034_0001);
    fpw(1'h0, 4'h5, 64'hAAAA_0000_BBBB_0001);
    chk("pair_dbl", 64'hAAAA_0000_BBBB_0001, fp_views_o.dbl[2]);
    chk("pair_ext", SB + 4, fp_views_o.ext[4]);
    $display("test views done");

    // Precision stays off with pair moves; reserved rounding codes get flagged
    for (int j = 0; j < 32; j++)
    begin
      wr(CFR_SEL_FP_STATUS_CONTROL, {11'h000, j[4], j[3] & !j[4], j[2], 16'h0000, j[1:0]});
      chk("fp_mode", {j[4], j[3] & !j[4], j[2:0], j[1]}, fp_mode_o);
    end
    $display("test modes done");

    wr(CFR_SEL_FP_STATUS_CONTROL, 32'h0004_0801);
    fpev(1'h1, 1'h0, 1'h1, 6'h11, 3'h4);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0005_1845);
    fpev(1'h1, 1'h0, 1'h1, 6'h01, 3'h0);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0004_1845);
    fpev(1'h1, 1'h0, 1'h0, 6'h00, 3'h0);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0004_0845);
    fpev(1'h1, 1'h0, 1'h1, 6'h20, 3'h4);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0006_0845);
    $display("test fp status done");

    wr(CFR_SEL_SR, 32'h7000_80F0);
    fpev(1'h1, 1'h0, 1'h0, 6'h00, 3'h2);
    fpev(1'h1, 1'h1, 1'h0, 6'h00, 3'h1);
    acc(1'h0, CFR_SEL_FP_STATUS_CONTROL, 32'h0000_0000, 1'h1);
    fpw(1'h0, 4'h0, 64'h0000_0000_DEAD_0001);
    chk("fd_ignored", SB, fp_views_o.single[0]);
    wr(CFR_SEL_SR, 32'h7000_00F0);
    $display("test fpu disable done");

    wr(CFR_SEL_VBR, 32'h8000_0000);
    wr(CFR_SEL_DBR, 32'h9000_0000);
    wr(CFR_SEL_SR, 32'h4000_0050);
    chk("mode_bits", 3'h4, {privilege_level_o, gpr_bank_select_o, exception_block_o});
    irq(4'h6, 1'h1);
    irq(4'h5, 1'h0);
    exc(1'h0, 32'h1234_5678, 32'hCAFE_0001, 1'h0);
    rd(CFR_SEL_SSR, 32'h4000_0050);
    rd(CFR_SEL_SPC, 32'h1234_5678);
    rd(CFR_SEL_SGR, 32'hCAFE_0001);
    rd(CFR_SEL_SR, 32'h7000_0050);
    chk("pc_vector", 32'h8000_0600, pc_o);
    irq(4'h6, 1'h0);
    // A user break under the block bit is saved, not escalated
    exc(1'h1, 32'h0000_2000, 32'h0000_0003, 1'h0);
    chk("pc_debug", 32'h9000_0000, pc_o);
    rd(CFR_SEL_SSR, 32'h7000_0050);
    $display("test exceptions done");

    wr(CFR_SEL_SR, 32'h0000_0000);
    chk("user_mode", 1'h0, privilege_level_o);
    acc(1'h0, CFR_SEL_VBR, 32'h0000_0000, 1'h1);
    acc(1'h1, CFR_SEL_SR, 32'h7000_0000, 1'h1);
    wr(CFR_SEL_GBR, 32'h5A5A_0001);
    rd(CFR_SEL_GBR, 32'h5A5A_0001);
    // Accumulators, link and FP_INT_TRANSFER_WORD stay open in user mode; FP_STATUS_CONTROL skipped here
    for (int s = 7; s < 12; s++)
    begin
      if (s != 10)
      begin
        wr(cfr_ctl_sel_e'(s), 32'h5A5A_0000 + s);
        rd(cfr_ctl_sel_e'(s), 32'h5A5A_0000 + s);
      end
    end
    exc(1'h0, 32'h0000_3000, 32'h0000_0004, 1'h0);
    rd(CFR_SEL_SR, 32'h7000_0000);
    exc(1'h0, 32'h0000_4000, 32'h0000_0005, 1'h1);
    rd(CFR_SEL_SR, 32'h7000_00F0);
    rd(CFR_SEL_VBR, 32'h0000_0000);
    rd(CFR_SEL_FP_STATUS_CONTROL, 32'h0004_0001);
    chk("pc_reset", 32'hA000_0000, pc_o);
    $display("test user mode and blocked exception done");
    conclude();
  end
endmodule
